// ===== shared/sysclk_pkg.sv
// constants and types for system clock select, divide and low power control
package sysclk_pkg;
  localparam logic [7:0] SYS_CLK_SELECT_ADDR  = 8'hA9;
  localparam logic [7:0] SYS_CLK_SELECT_RESET = 8'h82;
  localparam logic [7:0] PMU_CFG_ADDR         = 8'hB3;
  localparam logic [7:0] WAKE_EN_ADDR         = 8'hB4;
  localparam int READY_BIT    = 7;
  localparam int DIV_MSB      = 6;
  localparam int DIV_LSB      = 4;
  localparam int SRC_MSB      = 2;
  localparam int SRC_LSB      = 0;
  localparam int SLEEP_BIT    = 7;
  localparam int SUSPEND_BIT  = 6;
  localparam int RST_FLAG_BIT = 5;
  localparam int NUM_WAKE     = 5;
  localparam logic [4:0] WAKE_EN_RESET = 5'h00;
  localparam logic [2:0] SRC_PRECISION = 3'h0;
  localparam logic [2:0] SRC_EXTERNAL  = 3'h1;
  localparam logic [2:0] SRC_LP_DIV8   = 3'h2;
  localparam logic [2:0] SRC_RTC       = 3'h3;
  localparam logic [2:0] SRC_LP        = 3'h4;
  localparam logic [6:0] MAX_DIV_COUNT = 7'h7F;
  localparam int WAKE_HIDE_CYCLES = 2;
  localparam int CLK_PERIOD_NS    = 50;
  localparam int RESUSPEND_NS     = 15000;
  localparam int RESUSPEND_CYCLES =
    (RESUSPEND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_REQ_CYCLES  = 16;
  typedef enum logic [3:0] {
    PM_ACTIVE  = 4'b0001,
    PM_SUSPEND = 4'b0010,
    PM_SLEEP   = 4'b0100,
    PM_WAKE    = 4'b1000
  } pm_state_t;
  typedef enum logic [2:0] {
    SW_RUN      = 3'b001,
    SW_WAIT_OLD = 3'b010,
    SW_WAIT_NEW = 3'b100
  } sw_state_t;
endpackage

// ===== shared/clk_ctl_if.sv
// control bundle between power control and the clock generator
interface clk_ctl_if;
  logic [2:0] src_sel;
  logic [2:0] div_sel;
  logic       gate;
  logic [3:0] osc_sync;
  logic       div_applied;
  logic       sys_clk_en;
  modport gen (input src_sel, input div_sel, input gate, input osc_sync,
               output div_applied, output sys_clk_en);
  modport ctl (output src_sel, output div_sel, output gate,
               output osc_sync, input div_applied, input sys_clk_en);
endinterface

// ===== design/sysclk_gen.sv
// source multiplexer and power-of-two divider producing a clock enable
module sysclk_gen (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  clk_ctl_if.gen    ctl
);
  logic [3:0]               osc_d;
  logic [3:0]               rise;
  logic [2:0]               lp_cnt;
  logic                     lp8_tick;
  logic [2:0]               cur_src;
  logic [2:0]               new_src;
  logic [2:0]               cur_div;
  logic [6:0]               cnt;
  sysclk_pkg::sw_state_t    sw_state;
  logic                     src_tick;

  // bit order of osc_sync: precision, external, rtc, low power
  function automatic logic tick_of(input logic [2:0] s, input logic [3:0] r,
                                   input logic l8);
    case (s)
      sysclk_pkg::SRC_PRECISION: tick_of = r[0];
      sysclk_pkg::SRC_EXTERNAL:  tick_of = r[1];
      sysclk_pkg::SRC_LP_DIV8:   tick_of = l8;
      sysclk_pkg::SRC_RTC:       tick_of = r[2];
      sysclk_pkg::SRC_LP:        tick_of = r[3];
      default:                   tick_of = 1'b0;
    endcase
  endfunction

  // terminal count for divide by two to the field value
  function automatic logic [6:0] div_limit(input logic [2:0] d);
    div_limit = sysclk_pkg::MAX_DIV_COUNT >> (3'h7 - d);
  endfunction

  assign rise     = ctl.osc_sync & ~osc_d;
  assign lp8_tick = rise[3] && (lp_cnt == 3'h7);
  assign src_tick = (sw_state == sysclk_pkg::SW_RUN) &&
                    tick_of(cur_src, rise, lp8_tick);

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_d  <= 4'h0;
      lp_cnt <= 3'h0;
    end else begin
      osc_d <= ctl.osc_sync;
      if (rise[3]) begin
        lp_cnt <= lp_cnt + 3'h1;
      end
    end
  end

  // switch waits one edge of the old source then one of the new source
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_state <= sysclk_pkg::SW_RUN;
      cur_src  <= sysclk_pkg::SYS_CLK_SELECT_RESET[2:0];
      new_src  <= sysclk_pkg::SYS_CLK_SELECT_RESET[2:0];
    end else begin
      case (sw_state)
        sysclk_pkg::SW_RUN: begin
          if (ctl.src_sel != cur_src && cnt == 7'h00) begin
            new_src  <= ctl.src_sel;
            sw_state <= sysclk_pkg::SW_WAIT_OLD;
          end
        end
        sysclk_pkg::SW_WAIT_OLD: begin
          if (tick_of(cur_src, rise, lp8_tick) || ctl.gate) begin
            sw_state <= sysclk_pkg::SW_WAIT_NEW;
          end
        end
        sysclk_pkg::SW_WAIT_NEW: begin
          if (tick_of(new_src, rise, lp8_tick) || ctl.gate) begin
            cur_src  <= new_src;
            sw_state <= sysclk_pkg::SW_RUN;
          end
        end
        default: sw_state <= sysclk_pkg::SW_RUN;
      endcase
    end
  end

  // divide ratio only changes at the end of a full divided period
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt            <= 7'h00;
      cur_div        <= sysclk_pkg::SYS_CLK_SELECT_RESET[6:4];
      ctl.sys_clk_en <= 1'b0;
    end else begin
      ctl.sys_clk_en <= 1'b0;
      if (src_tick && !ctl.gate) begin
        if (cnt >= div_limit(cur_div)) begin
          cnt            <= 7'h00;
          cur_div        <= ctl.div_sel;
          ctl.sys_clk_en <= 1'b1;
        end else begin
          cnt <= cnt + 7'h01;
        end
      end
    end
  end

  // combinational so a read right after a divide write already shows 0
  always_comb begin
    ctl.div_applied = (cur_div == ctl.div_sel);
  end
endmodule // sysclk_gen

// ===== design/sysclk_ctrl.sv
// system clock select registers and suspend / sleep power control
module sysclk_ctrl (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  input  wire logic [3:0] osc_i,
  input  wire logic [4:0] wake_src_i,
  input  wire logic       rst_pin_low_i,
  output logic            sys_clk_en_o,
  output logic            prec_osc_en_o,
  output logic            lp_osc_en_o,
  output logic            core_reg_on_o,
  output logic            ram_on_vdd_o,
  output logic            gpio_hold_o,
  output logic            port_match_on_o,
  output logic            wake_request_n_o
);
  clk_ctl_if ctl ();

  logic [3:0]              osc_s1;
  logic [3:0]              osc_s2;
  logic [5:0]              ev_s1;
  logic [5:0]              ev_s2;
  logic [5:0]              ev_s3;
  logic [5:0]              ev_rise;
  logic [2:0]              src_reg;
  logic [2:0]              div_reg;
  logic [4:0]              wake_en;
  logic [5:0]              wake_flags;
  logic [5:0]              flag_clr;
  sysclk_pkg::pm_state_t   pm_state;
  logic [1:0]              hide_cnt;
  logic [8:0]              holdoff_cnt;
  logic [4:0]              wreq_cnt;
  logic                    wr_clk;
  logic                    wr_pmu;
  logic                    wr_en;
  logic                    wake_hit;
  logic                    low_power;

  assign wr_clk  = sfr_wr_i && (sfr_addr_i == sysclk_pkg::SYS_CLK_SELECT_ADDR);
  assign wr_pmu  = sfr_wr_i && (sfr_addr_i == sysclk_pkg::PMU_CFG_ADDR);
  assign wr_en   = sfr_wr_i && (sfr_addr_i == sysclk_pkg::WAKE_EN_ADDR);
  assign ev_rise = ev_s2 & ~ev_s3;
  assign wake_hit = |(ev_rise[4:0] & wake_en);
  assign low_power = (pm_state == sysclk_pkg::PM_SUSPEND) ||
                     (pm_state == sysclk_pkg::PM_SLEEP);
  assign flag_clr = wr_pmu ? sfr_wdata_i[5:0] : 6'h00;

  assign ctl.src_sel  = src_reg;
  assign ctl.div_sel  = div_reg;
  assign ctl.gate     = low_power;
  assign ctl.osc_sync = osc_s2;
  assign sys_clk_en_o = ctl.sys_clk_en;

  sysclk_gen u_gen (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .ctl        (ctl.gen)
  );

  // pins and oscillators are foreign to this clock: two flops first
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_s1 <= 4'h0;
      osc_s2 <= 4'h0;
      ev_s1  <= 6'h00;
      ev_s2  <= 6'h00;
      ev_s3  <= 6'h00;
    end else begin
      osc_s1 <= osc_i;
      osc_s2 <= osc_s1;
      ev_s1  <= {rst_pin_low_i, wake_src_i};
      ev_s2  <= ev_s1;
      ev_s3  <= ev_s2;
    end
  end

  // reserved source codes leave the current selection in place
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_reg <= sysclk_pkg::SYS_CLK_SELECT_RESET[2:0];
      div_reg <= sysclk_pkg::SYS_CLK_SELECT_RESET[6:4];
    end else if (wr_clk) begin
      div_reg <= sfr_wdata_i[6:4];
      if (sfr_wdata_i[2:0] <= sysclk_pkg::SRC_LP) begin
        src_reg <= sfr_wdata_i[2:0];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_en <= sysclk_pkg::WAKE_EN_RESET;
    end else if (wr_en) begin
      wake_en <= sfr_wdata_i[4:0];
    end
  end

  // flags are set only while powered down; set beats a same-cycle clear
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wake_flags <= 6'h00;
    end else begin
      wake_flags <= (wake_flags & ~flag_clr) |
                    (low_power ? ev_rise : 6'h00);
    end
  end

  // power state machine
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pm_state <= sysclk_pkg::PM_ACTIVE;
    end else begin
      case (pm_state)
        sysclk_pkg::PM_ACTIVE: begin
          if (wr_pmu && sfr_wdata_i[sysclk_pkg::SLEEP_BIT]) begin
            pm_state <= sysclk_pkg::PM_SLEEP;
          end else if (wr_pmu && sfr_wdata_i[sysclk_pkg::SUSPEND_BIT] &&
                       holdoff_cnt == 9'h000) begin
            pm_state <= sysclk_pkg::PM_SUSPEND;
          end
        end
        sysclk_pkg::PM_SUSPEND: begin
          if (wake_hit || ev_rise[sysclk_pkg::RST_FLAG_BIT]) begin
            pm_state <= sysclk_pkg::PM_WAKE;
          end
        end
        sysclk_pkg::PM_SLEEP: begin
          if (wake_hit) begin
            pm_state <= sysclk_pkg::PM_WAKE;
          end
        end
        sysclk_pkg::PM_WAKE: begin
          if (hide_cnt == 2'(sysclk_pkg::WAKE_HIDE_CYCLES - 1)) begin
            pm_state <= sysclk_pkg::PM_ACTIVE;
          end
        end
        default: pm_state <= sysclk_pkg::PM_ACTIVE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hide_cnt <= 2'h0;
    end else if (pm_state == sysclk_pkg::PM_WAKE) begin
      hide_cnt <= hide_cnt + 2'h1;
    end else begin
      hide_cnt <= 2'h0;
    end
  end

  // a reset-pin wake blocks re-suspend so a real pin reset can land
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      holdoff_cnt <= 9'h000;
    end else if (pm_state == sysclk_pkg::PM_SUSPEND &&
                 ev_rise[sysclk_pkg::RST_FLAG_BIT]) begin
      holdoff_cnt <= 9'(sysclk_pkg::RESUSPEND_CYCLES);
    end else if (holdoff_cnt != 9'h000) begin
      holdoff_cnt <= holdoff_cnt - 9'h001;
    end
  end

  // wake request held low a fixed time after leaving sleep
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wreq_cnt         <= 5'h00;
      wake_request_n_o <= 1'b1;
    end else begin
      if (pm_state == sysclk_pkg::PM_SLEEP && wake_hit) begin
        wreq_cnt <= 5'(sysclk_pkg::WAKE_REQ_CYCLES);
      end else if (wreq_cnt != 5'h00) begin
        wreq_cnt <= wreq_cnt - 5'h01;
      end
      wake_request_n_o <= !((pm_state == sysclk_pkg::PM_SLEEP && wake_hit) ||
                            wreq_cnt > 5'h01);
    end
  end

  // power and pad controls, registered
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prec_osc_en_o   <= 1'b1;
      lp_osc_en_o     <= 1'b1;
      core_reg_on_o   <= 1'b1;
      ram_on_vdd_o    <= 1'b0;
      gpio_hold_o     <= 1'b0;
      port_match_on_o <= 1'b0;
    end else begin
      prec_osc_en_o   <= !low_power;
      lp_osc_en_o     <= !low_power;
      core_reg_on_o   <= pm_state != sysclk_pkg::PM_SLEEP;
      ram_on_vdd_o    <= pm_state == sysclk_pkg::PM_SLEEP;
      gpio_hold_o     <= pm_state == sysclk_pkg::PM_SLEEP;
      port_match_on_o <= pm_state == sysclk_pkg::PM_SLEEP;
    end
  end

  // read data registered; unmapped addresses read zero
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      case (sfr_addr_i)
        sysclk_pkg::SYS_CLK_SELECT_ADDR:
          sfr_rdata_o <= {ctl.div_applied, div_reg, 1'b0, src_reg};
        sysclk_pkg::PMU_CFG_ADDR:
          sfr_rdata_o <= {2'h0, (pm_state == sysclk_pkg::PM_WAKE) ?
                          6'h00 : wake_flags};
        sysclk_pkg::WAKE_EN_ADDR:
          sfr_rdata_o <= {3'h0, wake_en};
        default:
          sfr_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule // sysclk_ctrl

// ===== testbench/sysclk_chk.sv
// port checker for clock select, divide and low power control
module sysclk_chk (
  input wire logic       core_clk_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic       sys_clk_en_o,
  input wire logic       prec_osc_en_o,
  input wire logic       lp_osc_en_o,
  input wire logic       core_reg_on_o,
  input wire logic       ram_on_vdd_o,
  input wire logic       gpio_hold_o,
  input wire logic       port_match_on_o,
  input wire logic       wake_request_n_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] low_cnt;
  logic [2:0] wr_div;
  // counts low samples so the full request width is judged at its end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) low_cnt <= 8'h00;
    else if (wake_request_n_o) low_cnt <= 8'h00;
    else low_cnt <= low_cnt + 8'h01;
  end
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) wr_div <= 3'h0;
    else if (sfr_wr_i && sfr_addr_i == sysclk_pkg::SYS_CLK_SELECT_ADDR)
      wr_div <= sfr_wdata_i[6:4];
  end
  sequence s_sel_wr;
    sfr_wr_i && sfr_addr_i == sysclk_pkg::SYS_CLK_SELECT_ADDR;
  endsequence
  sequence s_sel_rd;
    sfr_rd_i && sfr_addr_i == sysclk_pkg::SYS_CLK_SELECT_ADDR;
  endsequence
  a_wake_req_len:
    assert property ($rose(wake_request_n_o) |-> low_cnt == 8'h10)
    else $error("wake request low time wrong");
  a_sleep_exit_req:
    assert property ($rose(core_reg_on_o) |-> ##[0:3] !wake_request_n_o)
    else $error("no wake request after sleep exit");
  a_sleep_pads:
    assert property (ram_on_vdd_o |-> gpio_hold_o && port_match_on_o)
    else $error("pads not held in sleep");
  a_sleep_regulator:
    assert property (ram_on_vdd_o |-> !core_reg_on_o)
    else $error("regulator on while ram on main supply");
  a_sleep_no_clk:
    assert property (ram_on_vdd_o && $past(ram_on_vdd_o) |-> !sys_clk_en_o)
    else $error("system clock runs in sleep");
  a_susp_no_clk:
    assert property (!prec_osc_en_o && !lp_osc_en_o && !$past(prec_osc_en_o)
      |-> !sys_clk_en_o)
    else $error("system clock runs with oscillators off");
  a_pulse_single:
    assert property (sys_clk_en_o |=> !sys_clk_en_o)
    else $error("shortened system clock period");
  a_sel_bit3:
    assert property (s_sel_rd |=> !sfr_rdata_o[3])
    else $error("unused select bit reads one");
  a_sel_readback:
    assert property (s_sel_wr ##1 s_sel_rd |=> sfr_rdata_o[6:4] == wr_div)
    else $error("divide field readback wrong");
endmodule // sysclk_chk

bind sysclk_ctrl sysclk_chk u_sysclk_chk (.core_clk_i, .rst_n_i, .sfr_addr_i,
  .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .sys_clk_en_o,
  .prec_osc_en_o, .lp_osc_en_o, .core_reg_on_o, .ram_on_vdd_o, .gpio_hold_o,
  .port_match_on_o, .wake_request_n_o);

// ===== testbench/tb.sv
// self-checking bench for clock select, divide and low power control
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk_i, rst_n_i, sfr_wr_i, sfr_rd_i, rst_pin_low_i;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, v;
  logic [3:0] osc_i;
  logic [4:0] wake_src_i;
  logic       sys_clk_en_o, prec_osc_en_o, lp_osc_en_o, core_reg_on_o;
  logic       ram_on_vdd_o, gpio_hold_o, port_match_on_o, wake_request_n_o;
  int         failures, checks_done, cycles, n, i;
  logic [23:0] rows [12] = '{
    {8'h00, 16'h0002}, {8'h10, 16'h0004}, {8'h20, 16'h0008},
    {8'h30, 16'h0010}, {8'h40, 16'h0020}, {8'h50, 16'h0040},
    {8'h60, 16'h0080}, {8'h70, 16'h0100}, {8'h01, 16'h0004},
    {8'h03, 16'h0008}, {8'h04, 16'h0010}, {8'h02, 16'h0080}};
  sysclk_ctrl u_sysclk_ctrl (.core_clk_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i,
    .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .osc_i, .wake_src_i,
    .rst_pin_low_i, .sys_clk_en_o, .prec_osc_en_o, .lp_osc_en_o,
    .core_reg_on_o, .ram_on_vdd_o, .gpio_hold_o, .port_match_on_o,
    .wake_request_n_o);
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  // oscillators as counter bits: periods of 2, 4, 8 and 16 cycles
  always @(posedge core_clk_i) osc_i <= osc_i + 4'h1;
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge core_clk_i);
    sfr_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge core_clk_i);
    sfr_rd_i <= 1'b0;
    @(posedge core_clk_i);
    d = sfr_rdata_o;
  endtask
  // polls the ready flag; a bounded wait so a stuck flag cannot hang
  task automatic rdy(output logic [7:0] d);
    for (int k = 0; k < 200; k++) begin
      rd(8'hA9, d);
      if (d[7] === 1'b1) break;
    end
  endtask
  task automatic wp(input int lim, output int c);
    for (c = 1; c < lim; c++) begin
      @(posedge core_clk_i);
      if (sys_clk_en_o === 1'b1) break;
    end
  endtask
  task automatic pw(input logic [4:0] w, input logic r);
    wake_src_i <= w;
    rst_pin_low_i <= r;
    cyc(4);
    wake_src_i <= 5'h00;
    rst_pin_low_i <= 1'b0;
    cyc(1);
  endtask
  initial begin
    rst_n_i = 1'b0;
    osc_i = 4'h0;
    wake_src_i = 5'h00;
    rst_pin_low_i = 1'b0;
    sfr_addr_i = 8'h00;
    sfr_wdata_i = 8'h00;
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
    cyc(4);
    rst_n_i <= 1'b1;
    cyc(1);
    rd(8'hA9, v);
    chk(v, 16'h0082);
    foreach (rows[r]) begin
      wr(8'hA9, rows[r][23:16]);
      rdy(v);
      chk(v, {8'h00, 8'h80 | rows[r][23:16]});
      wp(600, n);
      wp(600, n);
      wp(600, n);
      chk(n, rows[r][15:0]);
    end
    wr(8'hA9, 8'h70);
    rdy(v);
    // leaving divide by 128: the change waits for the long period to end
    wr(8'hA9, 8'h00);
    rd(8'hA9, v);
    chk(v, 16'h0000);
    rdy(v);
    chk(v, 16'h0080);
    wr(8'hA9, 8'h05);
    rdy(v);
    chk(v, 16'h0080);
    wr(8'hA9, 8'h08);
    rdy(v);
    chk(v, 16'h0080);
    // divide by one and precision source set before suspend
    wr(8'hB4, 8'h1F);
    cyc(1);
    wr(8'hB3, 8'h40);
    cyc(6);
    chk({prec_osc_en_o, lp_osc_en_o}, 16'h0000);
    wp(40, n);
    chk(n, 16'd40);
    pw(5'h04, 1'b0);
    wp(60, n);
    chk(n < 60, 16'h0001);
    rd(8'hB3, v);
    chk(v, 16'h0004);
    wr(8'hB3, 8'h3F);
    cyc(1);
    wr(8'hB3, 8'h40);
    cyc(6);
    pw(5'h00, 1'b1);
    wp(60, n);
    rd(8'hB3, v);
    chk(v, 16'h0020);
    wr(8'hB3, 8'h3F);
    cyc(1);
    wr(8'hB3, 8'h40);
    cyc(6);
    chk(prec_osc_en_o, 16'h0001);
    cyc(300);
    wr(8'hB4, 8'h1E);
    cyc(1);
    wr(8'hB3, 8'h40);
    cyc(6);
    chk(prec_osc_en_o, 16'h0000);
    pw(5'h01, 1'b0);
    cyc(20);
    chk(prec_osc_en_o, 16'h0000);
    pw(5'h10, 1'b0);
    wp(60, n);
    chk(prec_osc_en_o, 16'h0001);
    // low-power source around sleep; osc enable bit lives elsewhere
    wr(8'hA9, 8'h04);
    cyc(1);
    wr(8'hB3, 8'h80);
    cyc(6);
    chk({core_reg_on_o, ram_on_vdd_o, gpio_hold_o, port_match_on_o},
        16'h0007);
    // count every low sample from the wake event on, none missed
    wake_src_i <= 5'h08;
    n = 0;
    for (i = 0; i < 40; i++) begin
      @(posedge core_clk_i);
      if (wake_request_n_o === 1'b0) n++;
    end
    wake_src_i <= 5'h00;
    chk(n, 16'd16);
    chk(core_reg_on_o, 16'h0001);
    wr(8'hA9, 8'h00);
    rdy(v);
    chk(v, 16'h0080);
    // flash one-shot bypass above 10 MHz is left to software
    rst_n_i <= 1'b0;
    cyc(2);
    rst_n_i <= 1'b1;
    cyc(1);
    rd(8'hA9, v);
    chk(v, 16'h0082);
    chk({wake_request_n_o, prec_osc_en_o, core_reg_on_o, ram_on_vdd_o},
        16'h000E);
    tally_and_finish();
  end
endmodule // tb
